// >>> design/psw_config_regs.sv
// Configuration bank: multi-function pin, pulse switch, thermal and
// current settings, two scratch bytes, reached over a 16-bit frame.
// Assumes mode, lock and reset event inputs are on clk; the serial
// link and the pin level come from outside and are synchronised here.
`timescale 1ns/1ps

module psw_config_regs #(
   parameter int SLICE_CYC_RATE0 = psw_pkg::SLICE_CYC_0,
   parameter int SLICE_CYC_RATE1 = psw_pkg::SLICE_CYC_1,
   parameter int SLICE_CYC_RATE2 = psw_pkg::SLICE_CYC_2,
   parameter int SLICE_CYC_RATE3 = psw_pkg::SLICE_CYC_3,
   parameter int WAKE_FILTER_CYC = psw_pkg::WAKE_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       linkClk,
   input  wire logic       linkSelect_n,
   input  wire logic       linkDataIn,
   output logic            linkDataOut,
   output logic            linkDataOutEnable,
   input  wire logic       softReset,
   input  wire logic       normalMode,
   input  wire logic       stopMode,
   input  wire logic       failSafeMode,
   input  wire logic       lockLevel0,
   input  wire logic       lockLevel1Set,
   input  wire logic       failSignal,
   input  wire logic       cyclicSenseOn,
   input  wire logic       pinLevel,
   output logic            pinHighSide,
   output logic            pinLowSide,
   output logic            pinFailOut,
   output logic            wakeEnable,
   output logic            wakeLevel,
   output logic            failSafeWake,
   output logic            thermalHigh,
   output logic [1:0]      curLimit
);

   // ==========================================================
   // Helper functions
   function automatic logic [psw_pkg::SLICE_CNT_W-1:0] sliceEnd(
      input logic [1:0] rateSel);
      logic [psw_pkg::SLICE_CNT_W-1:0] v;
      v = '0;
      case (rateSel)
         2'h0:    v = psw_pkg::SLICE_CNT_W'(SLICE_CYC_RATE0 - 1);
         2'h1:    v = psw_pkg::SLICE_CNT_W'(SLICE_CYC_RATE1 - 1);
         2'h2:    v = psw_pkg::SLICE_CNT_W'(SLICE_CYC_RATE2 - 1);
         default: v = psw_pkg::SLICE_CNT_W'(SLICE_CYC_RATE3 - 1);
      endcase
      return v;
   endfunction : sliceEnd

   function automatic logic [7:0] readValue(
      input logic [6:0]        addr,
      input psw_pkg::psw_core_t s,
      input logic              scratchReadable);
      logic [7:0] v;
      v = 8'h00;
      case (addr)
         psw_pkg::ADDR_PIN_FUNC: v = {5'h00, s.pinFunc};
         psw_pkg::ADDR_DUTY:     v = s.duty;
         psw_pkg::ADDR_RATE:     v = {6'h00, s.rate};
         psw_pkg::ADDR_THERM:    v = {5'h00, s.thermalHigh, s.curLimit};
         psw_pkg::ADDR_SCR_LOW:  v = scratchReadable ? s.scratchLow  : 8'h00;
         psw_pkg::ADDR_SCR_HIGH: v = scratchReadable ? s.scratchHigh : 8'h00;
         default:                v = 8'h00;
      endcase
      return v;
   endfunction : readValue

   // ==========================================================
   // Link side: frame capture on rising link clock
   logic [4:0]    bitCnt;
   logic [15:0]   frameWord;
   logic          frameOk;
   logic [6:0]    addrHold;
   logic          addrReady;
   logic [7:0]    misoShift;
   psw_pkg::psw_core_t core;
   psw_pkg::psw_core_t next_core;

   // Bit count and address flag clear whenever chip select is high
   always_ff @(posedge linkClk or posedge linkSelect_n)
   begin
      if (linkSelect_n)
      begin
         bitCnt    <= 5'h00;
         addrReady <= 1'b0;
      end
      else
      begin
         if (bitCnt != psw_pkg::BIT_CNT_SAT)
         begin
            bitCnt <= bitCnt + 5'h01;
         end
         if (bitCnt == psw_pkg::ADDR_LAST_BIT)
         begin
            addrReady <= 1'b1;
         end
      end
   end

   always_ff @(posedge linkClk)
   begin
      if (bitCnt < psw_pkg::BIT_CNT_SAT)
      begin
         frameWord[bitCnt[3:0]] <= linkDataIn;
      end
      frameOk <= (bitCnt == psw_pkg::FRAME_LAST_BIT);
      if (bitCnt == psw_pkg::ADDR_LAST_BIT)
      begin
         addrHold  <= {linkDataIn, frameWord[5:0]};
      end
   end

   // Read data launched on falling edge, LSB first
   always_ff @(negedge linkClk or posedge linkSelect_n)
   begin
      if (linkSelect_n)
      begin
         misoShift   <= 8'h00;
         linkDataOut <= 1'b0;
      end
      else if (bitCnt == psw_pkg::DATA_START_BIT)
      begin
         misoShift   <= {1'b0, core.readHold[7:1]};
         linkDataOut <= core.readHold[0];
      end
      else
      begin
         misoShift   <= {1'b0, misoShift[7:1]};
         linkDataOut <= misoShift[0];
      end
   end

   // ==========================================================
   // Core side

   logic          frameEnd;
   logic          wrStrobe;
   logic [6:0]    wrAddr;
   logic [7:0]    wrData;
   logic          periodEnd;

   always_comb
   begin
      next_core = core;

      // Synchronisers
      next_core.reqSync1 = addrReady;
      next_core.reqSync2 = core.reqSync1;
      next_core.csnSync1 = linkSelect_n;
      next_core.csnSync2 = core.csnSync1;
      next_core.csnPrev  = core.csnSync2;
      next_core.pinSync1 = pinLevel;
      next_core.pinSync2 = core.pinSync1;

      // Read request answered while address is stable
      next_core.reqSeen = core.reqSync2;
      if (core.reqSync2 && !core.reqSeen)
      begin
         next_core.readHold = readValue(addrHold, core,
                                        normalMode | stopMode);
      end

      frameEnd = core.csnSync2 & ~core.csnPrev;
      wrStrobe = frameEnd & frameOk & frameWord[psw_pkg::MODE_BIT];
      wrAddr   = frameWord[psw_pkg::ADDR_W-1:0];
      wrData   = frameWord[psw_pkg::DATA_LSB +: psw_pkg::DATA_W];

      if (wrStrobe)
      begin
         case (wrAddr)
            psw_pkg::ADDR_PIN_FUNC:
            begin
               if (!lockLevel0)
               begin
                  next_core.pinFunc = wrData[2:0];
               end
            end
            psw_pkg::ADDR_DUTY: next_core.duty = wrData;
            psw_pkg::ADDR_RATE: next_core.rate = wrData[1:0];
            psw_pkg::ADDR_THERM:
            begin
               if (!core.lock1Active)
               begin
                  next_core.thermalHigh = wrData[psw_pkg::THERM_BIT];
                  next_core.curLimit    = wrData[1:0];
               end
            end
            psw_pkg::ADDR_SCR_LOW:
            begin
               if (normalMode)
               begin
                  next_core.scratchLow = wrData;
               end
            end
            psw_pkg::ADDR_SCR_HIGH:
            begin
               if (normalMode)
               begin
                  next_core.scratchHigh = wrData;
               end
            end
            default: next_core.duty = next_core.duty;
         endcase
      end

      if (frameEnd & lockLevel1Set)
      begin
         next_core.lock1Active = 1'b1;
      end

      // Soft reset beats a same-cycle write; scratch untouched
      if (softReset)
      begin
         if (!lockLevel0)
         begin
            next_core.pinFunc = psw_pkg::PIN_FUNC_POR;
         end
         next_core.duty = psw_pkg::DUTY_POR;
         next_core.rate = psw_pkg::RATE_POR;
         if (!core.lock1Active)
         begin
            next_core.thermalHigh = psw_pkg::THERM_POR;
            next_core.curLimit    = psw_pkg::CUR_LIMIT_POR;
         end
      end

      // Pulse generator: 255 slices per period
      periodEnd = (core.sliceCnt == sliceEnd(core.activeRate)) &&
                  (core.sliceIdx == psw_pkg::SLICE_LAST);
      if (core.sliceCnt == sliceEnd(core.activeRate))
      begin
         next_core.sliceCnt = '0;
         next_core.sliceIdx = core.sliceIdx + 8'h01;
      end
      else
      begin
         next_core.sliceCnt = core.sliceCnt + 1'b1;
      end
      if (periodEnd)
      begin
         next_core.sliceIdx   = 8'h00;
         next_core.activeDuty = core.duty;
         next_core.activeRate = core.rate;
      end
      next_core.switchOn = (core.activeDuty == psw_pkg::DUTY_FULL) ||
                           (core.sliceIdx < core.activeDuty);

      if (core.pinSync2 == core.wakeLevel)
      begin
         next_core.wakeCnt = '0;
      end
      else if (core.wakeCnt == psw_pkg::WAKE_CNT_W'(WAKE_FILTER_CYC - 1))
      begin
         next_core.wakeCnt   = '0;
         next_core.wakeLevel = core.pinSync2;
      end
      else
      begin
         next_core.wakeCnt = core.wakeCnt + 1'b1;
      end

      // Pin output decode
      next_core.pinHighSide = 1'b0;
      next_core.pinLowSide  = 1'b0;
      next_core.pinFailOut  = 1'b0;
      next_core.wakeEnable  = 1'b0;
      case (core.pinFunc)
         psw_pkg::PIN_FAIL_A,
         psw_pkg::PIN_FAIL_B,
         psw_pkg::PIN_FAIL_C: next_core.pinFailOut  = failSignal;
         psw_pkg::PIN_CYCLIC_HS: next_core.pinHighSide = cyclicSenseOn;
         psw_pkg::PIN_WAKE:     next_core.wakeEnable  = 1'b1;
         psw_pkg::PIN_PULSE_LS: next_core.pinLowSide  = core.switchOn;
         psw_pkg::PIN_PULSE_HS: next_core.pinHighSide = core.switchOn;
         default:               next_core.pinFailOut  = 1'b0;
      endcase
      next_core.failSafeWake = failSafeMode &&
                               (core.pinFunc == psw_pkg::PIN_WAKE);
      next_core.misoEnable   = ~core.csnSync2;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         core             <= '0;
         core.csnSync1    <= 1'b1;
         core.csnSync2    <= 1'b1;
         core.csnPrev     <= 1'b1;
         core.pinFunc     <= psw_pkg::PIN_FUNC_POR;
         core.curLimit    <= psw_pkg::CUR_LIMIT_POR;
         core.thermalHigh <= psw_pkg::THERM_POR;
         core.scratchLow  <= psw_pkg::SCRATCH_POR;
         core.scratchHigh <= psw_pkg::SCRATCH_POR;
      end
      else
      begin
         core <= next_core;
      end
   end

   // ==========================================================
   // Outputs
   assign pinHighSide       = core.pinHighSide;
   assign pinLowSide        = core.pinLowSide;
   assign pinFailOut        = core.pinFailOut;
   assign wakeEnable        = core.wakeEnable;
   assign wakeLevel         = core.wakeLevel;
   assign failSafeWake      = core.failSafeWake;
   assign thermalHigh       = core.thermalHigh;
   assign curLimit          = core.curLimit;
   assign linkDataOutEnable = core.misoEnable;

endmodule : psw_config_regs

// >>> design/psw_pkg.sv
// Constants, register map and state type for the pin, switch and
// protection configuration bank.
// Assumes a 125 MHz core clock and a 16-bit, LSB-first serial frame.
package psw_pkg;

   // ==========================================================
   // Serial frame layout
   localparam int            ADDR_W         = 7;
   localparam int            DATA_W         = 8;
   localparam logic [4:0]    FRAME_LAST_BIT = 5'h0f;
   localparam logic [4:0]    ADDR_LAST_BIT  = 5'h06;
   localparam logic [4:0]    DATA_START_BIT = 5'h08;
   localparam logic [4:0]    BIT_CNT_SAT    = 5'h10;
   localparam int            MODE_BIT       = 7;
   localparam int            DATA_LSB       = 8;

   // ==========================================================
   // Register addresses
   localparam logic [6:0]    ADDR_PIN_FUNC  = 7'h17;
   localparam logic [6:0]    ADDR_DUTY      = 7'h18;
   localparam logic [6:0]    ADDR_RATE      = 7'h1c;
   localparam logic [6:0]    ADDR_THERM     = 7'h1d;
   localparam logic [6:0]    ADDR_SCR_LOW   = 7'h1e;
   localparam logic [6:0]    ADDR_SCR_HIGH  = 7'h1f;

   // ==========================================================
   // Field positions and reset values
   localparam int            THERM_BIT      = 2;
   localparam logic [2:0]    PIN_FUNC_POR   = 3'h0;
   localparam logic [7:0]    DUTY_POR       = 8'h00;
   localparam logic [1:0]    RATE_POR       = 2'h0;
   localparam logic          THERM_POR      = 1'b0;
   localparam logic [1:0]    CUR_LIMIT_POR  = 2'h1;
   localparam logic [7:0]    SCRATCH_POR    = 8'h00;

   // ==========================================================
   // Pin function codes
   localparam logic [2:0]    PIN_FAIL_A     = 3'h0;
   localparam logic [2:0]    PIN_FAIL_B     = 3'h1;
   localparam logic [2:0]    PIN_FAIL_C     = 3'h2;
   localparam logic [2:0]    PIN_CYCLIC_HS  = 3'h3;
   localparam logic [2:0]    PIN_OFF        = 3'h4;
   localparam logic [2:0]    PIN_WAKE       = 3'h5;
   localparam logic [2:0]    PIN_PULSE_LS   = 3'h6;
   localparam logic [2:0]    PIN_PULSE_HS   = 3'h7;

   // ==========================================================
   // Pulse generator timing
   localparam logic [7:0]    DUTY_FULL      = 8'hff;
   localparam logic [7:0]    SLICE_LAST     = 8'hfe;
   localparam int            SLICES         = 255;
   localparam int            CLK_HZ         = 125_000_000;
   localparam int            CLK_PERIOD_NS  = 8;
   localparam int            RATE_HZ_0      = 100;
   localparam int            RATE_HZ_1      = 200;
   localparam int            RATE_HZ_2      = 325;
   localparam int            RATE_HZ_3      = 400;
   localparam int            SLICE_CYC_0    = CLK_HZ / (RATE_HZ_0 * SLICES);
   localparam int            SLICE_CYC_1    = CLK_HZ / (RATE_HZ_1 * SLICES);
   localparam int            SLICE_CYC_2    = CLK_HZ / (RATE_HZ_2 * SLICES);
   localparam int            SLICE_CYC_3    = CLK_HZ / (RATE_HZ_3 * SLICES);
   localparam int            SLICE_CNT_W    = 16;

   // Wake filter, least time rounded up
   localparam int            WAKE_FILTER_NS = 16000;
   localparam int            WAKE_CYCLES    =
      (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int            WAKE_CNT_W     = 12;

   // ==========================================================
   // Core clock state
   typedef struct packed {
      logic                      reqSync1;
      logic                      reqSync2;
      logic                      reqSeen;
      logic                      csnSync1;
      logic                      csnSync2;
      logic                      csnPrev;
      logic                      pinSync1;
      logic                      pinSync2;
      logic [7:0]                readHold;
      logic [2:0]                pinFunc;
      logic [7:0]                duty;
      logic [1:0]                rate;
      logic                      thermalHigh;
      logic [1:0]                curLimit;
      logic [7:0]                scratchLow;
      logic [7:0]                scratchHigh;
      logic                      lock1Active;
      logic [7:0]                activeDuty;
      logic [1:0]                activeRate;
      logic [SLICE_CNT_W-1:0]    sliceCnt;
      logic [7:0]                sliceIdx;
      logic                      switchOn;
      logic [WAKE_CNT_W-1:0]     wakeCnt;
      logic                      wakeLevel;
      logic                      pinHighSide;
      logic                      pinLowSide;
      logic                      pinFailOut;
      logic                      wakeEnable;
      logic                      failSafeWake;
      logic                      misoEnable;
   } psw_core_t;

endpackage : psw_pkg

// >>> sim/psw_config_regs_props.sv
// Port checker for the configuration bank.
// Assumes one clk domain with synchronous active-low reset_n.
`timescale 1ns/1ps
module psw_config_regs_props #(
   parameter int WAKE_FILTER_CYC = 8
) (
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic       linkSelect_n,
   input wire logic       softReset,
   input wire logic       failSafeMode,
   input wire logic       lockLevel1Set,
   input wire logic       failSignal,
   input wire logic       pinLevel,
   input wire logic       pinHighSide,
   input wire logic       pinLowSide,
   input wire logic       pinFailOut,
   input wire logic       wakeEnable,
   input wire logic       wakeLevel,
   input wire logic       failSafeWake,
   input wire logic       thermalHigh,
   input wire logic [1:0] curLimit
);
   logic [7:0] hiCnt;
   logic [7:0] sinceEvt;
   logic       selPrev;
   logic       lockSeen;
   logic       lockOn;
   logic       selRise;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // ==========
   // Helper state
   assign selRise = linkSelect_n && !selPrev;

   always_ff @(posedge clk)
   begin
      selPrev <= linkSelect_n;
      if (!reset_n)
      begin
         hiCnt <= 8'h00;
         sinceEvt <= 8'hff;
         lockSeen <= 1'b0;
         lockOn <= 1'b0;
      end
      else
      begin
         hiCnt <= !pinLevel ? 8'h00 : hiCnt + 8'(hiCnt != 8'hff);
         sinceEvt <= (selRise || softReset) ? 8'h00 :
            sinceEvt + 8'(sinceEvt != 8'hff);
         lockSeen <= lockSeen || lockLevel1Set;
         lockOn <= lockOn || (selRise && lockLevel1Set);
      end
   end

   // ==========
   // Port relations
   a_reset_vals: assert property (
      $rose(reset_n) |-> curLimit == 2'h1 && !thermalHigh && !wakeEnable)
      else $error("outputs not at power-on values");
   a_one_drive: assert property (
      $onehot0({pinHighSide, pinLowSide, pinFailOut, wakeEnable}))
      else $error("pin driven in two ways");
   a_fail_follow: assert property (
      pinFailOut |-> $past(failSignal) || $past(failSignal, 2))
      else $error("fail output without fail state");
   a_wake_rise: assert property (
      $rose(wakeLevel) |-> hiCnt >= WAKE_FILTER_CYC)
      else $error("wake level accepted too early");
   a_safe_wake: assert property (
      (wakeEnable && failSafeMode) [*3] |-> failSafeWake)
      else $error("wake pin not a fail-safe wake source");
   a_soft_default: assert property (
      softReset && !lockSeen |-> ##[1:3] curLimit == 2'h1 && !thermalHigh)
      else $error("soft reset left thermal or current setting");
   a_soft_locked: assert property (
      softReset && lockOn |=> ($stable(curLimit) && $stable(thermalHigh))[*2])
      else $error("locked setting changed by soft reset");
   a_cfg_cause: assert property (
      !$stable({thermalHigh, curLimit}) |-> sinceEvt <= 8'h06)
      else $error("setting changed without frame or soft reset");

   c_wake: cover property ($rose(wakeLevel));
   c_safe: cover property (failSafeWake);
   c_lock: cover property (softReset && lockOn);
endmodule : psw_config_regs_props

bind psw_config_regs psw_config_regs_props #(
   .WAKE_FILTER_CYC(WAKE_FILTER_CYC)
) props_u (
   .clk(clk), .reset_n(reset_n), .linkSelect_n(linkSelect_n),
   .softReset(softReset), .failSafeMode(failSafeMode),
   .lockLevel1Set(lockLevel1Set), .failSignal(failSignal),
   .pinLevel(pinLevel), .pinHighSide(pinHighSide), .pinLowSide(pinLowSide),
   .pinFailOut(pinFailOut), .wakeEnable(wakeEnable), .wakeLevel(wakeLevel),
   .failSafeWake(failSafeWake), .thermalHigh(thermalHigh),
   .curLimit(curLimit)
);

// >>> sim/psw_host_model.sv
// Host model: sends 16-bit frames, LSB first, on its own link clock.
// Assumes read data is launched on falling link clock edges.
`timescale 1ns/1ps
module psw_host_model (
   output logic      linkClk,
   output logic      linkSelect_n,
   output logic      linkDataIn,
   input  wire logic linkDataOut
);
   initial
   begin
      linkClk = 1'b0;
      linkSelect_n = 1'b0;
      linkDataIn = 1'b1;
      // One select rise clears the link side before any frame
      #1 linkSelect_n = 1'b1;
   end

   // ==========
   // One frame, 80 ns link period, clock idle low
   // host-only framed access
   task automatic xfer(input logic wr, input logic [6:0] addr,
      input logic [7:0] wd, output logic [7:0] rd);
      logic [15:0] frm;
      frm = {wd, wr, addr};
      rd = 8'h00;
      #3 linkSelect_n = 1'b0;
      for (int i = 0; i < 16; i++)
      begin
         linkDataIn = frm[i];
         #20 linkClk = 1'b1;
         if (i > 7) rd[i-8] = linkDataOut;
         #40 linkClk = 1'b0;
         #20;
      end
      linkSelect_n = 1'b1;
      // Released line shows no stale bit
      linkDataIn = ~frm[15];
      #100;
   endtask : xfer
endmodule : psw_host_model

// >>> sim/psw_tb.sv
// Self-checking bench for the configuration bank.
// Assumes the host model is the only path to the registers.
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0, reset_n = 1'b0, softReset = 1'b0, normalMode = 1'b1;
   logic stopMode = 1'b0, failSafeMode = 1'b0, lockLevel0 = 1'b0;
   logic lockLevel1Set = 1'b0, failSignal = 1'b0, cyclicSenseOn = 1'b0;
   logic pinLevel = 1'b0, linkClk, linkSelect_n, linkDataIn, linkDataOut;
   logic linkDataOutEnable, pinHighSide, pinLowSide, pinFailOut, wakeEnable;
   logic wakeLevel, failSafeWake, thermalHigh;
   logic [1:0] curLimit;
   logic [7:0] rd;
   int failCount = 0, nTests = 0, cycles = 0;

   always #4 clk = ~clk;

   psw_config_regs #(.SLICE_CYC_RATE0(4), .SLICE_CYC_RATE1(3),
      .SLICE_CYC_RATE2(2), .SLICE_CYC_RATE3(1), .WAKE_FILTER_CYC(8)
   ) dut_u (.clk(clk), .reset_n(reset_n), .linkClk(linkClk),
      .linkSelect_n(linkSelect_n), .linkDataIn(linkDataIn),
      .linkDataOut(linkDataOut), .linkDataOutEnable(linkDataOutEnable),
      .softReset(softReset), .normalMode(normalMode), .stopMode(stopMode),
      .failSafeMode(failSafeMode), .lockLevel0(lockLevel0),
      .lockLevel1Set(lockLevel1Set), .failSignal(failSignal),
      .cyclicSenseOn(cyclicSenseOn), .pinLevel(pinLevel),
      .pinHighSide(pinHighSide), .pinLowSide(pinLowSide),
      .pinFailOut(pinFailOut), .wakeEnable(wakeEnable),
      .wakeLevel(wakeLevel), .failSafeWake(failSafeWake),
      .thermalHigh(thermalHigh), .curLimit(curLimit));

   psw_host_model host_u (.linkClk(linkClk), .linkSelect_n(linkSelect_n),
      .linkDataIn(linkDataIn), .linkDataOut(linkDataOut));

   // ==========
   // Shared tasks
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      nTests++;
      if (got !== exp)
      begin
         failCount++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_byte

   task automatic chk_bit(input logic got, input logic exp);
      nTests++;
      if (got !== exp)
      begin
         failCount++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      host_u.xfer(1'b1, a, d, rd);
   endtask : wr

   task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
      host_u.xfer(1'b0, a, 8'h00, rd);
      chk_byte(rd, e);
   endtask : rdchk

   task automatic soft_pulse();
      @(posedge clk) softReset <= 1'b1;
      @(posedge clk) softReset <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : soft_pulse

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", nTests, failCount);
      if (failCount == 0 && nTests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run

   // ==========
   // Scenarios
   task automatic test_regs();
      logic [6:0] a [7] = '{7'h18, 7'h1c, 7'h1d, 7'h1e, 7'h1f, 7'h17, 7'h20};
      logic [7:0] p [7] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
      logic [7:0] m [7] = '{8'hff, 8'h03, 8'h07, 8'hff, 8'hff, 8'h07, 8'h00};
      for (int i = 0; i < 7; i++)
      begin
         rdchk(a[i], p[i]);
         wr(a[i], 8'hff);
         rdchk(a[i], m[i]);
      end
      chk_byte({5'h00, thermalHigh, curLimit}, 8'h07);
      fork
         rdchk(7'h17, 8'h07);
         begin
            repeat (50) @(negedge clk);
            chk_bit(linkDataOutEnable, 1'b1);
         end
      join
      chk_bit(linkDataOutEnable, 1'b0);
      $display("test_regs done");
   endtask : test_regs

   task automatic test_pins();
      repeat (600) @(posedge clk);
      for (int c = 0; c < 8; c++)
      begin
         @(posedge clk) failSignal <= !c[0];
         cyclicSenseOn <= c[0];
         wr(7'h17, 8'(c));
         repeat (4) @(negedge clk);
         chk_bit(pinFailOut, c < 3 && !c[0]);
         chk_bit(pinHighSide, c == 3 || c == 7);
         chk_bit(pinLowSide, c == 6);
         chk_bit(wakeEnable, c == 5);
      end
      $display("test_pins done");
   endtask : test_pins

   task automatic test_pulse();
      logic [7:0] dt [4] = '{8'h01, 8'h40, 8'h00, 8'h80};
      int sl;
      int n;
      for (int r = 3; r >= 0; r--)
      begin
         sl = 4 - r;
         n = 0;
         wr(7'h18, dt[r]);
         wr(7'h1c, 8'(r));
         repeat (510 * sl) @(negedge clk);
         repeat (255 * sl) @(negedge clk) n += pinHighSide;
         chk_byte(8'(n / sl), dt[r]);
         chk_bit(n % sl == 0, 1'b1);
      end
      $display("test_pulse done");
   endtask : test_pulse

   task automatic test_wake();
      wr(7'h17, 8'h05);
      @(posedge clk) pinLevel <= 1'b1;
      repeat (5) @(posedge clk);
      pinLevel <= 1'b0;
      repeat (12) @(negedge clk);
      chk_bit(wakeLevel, 1'b0);
      @(posedge clk) pinLevel <= 1'b1;
      failSafeMode <= 1'b1;
      repeat (20) @(negedge clk);
      chk_bit(wakeLevel, 1'b1);
      chk_bit(failSafeWake, 1'b1);
      @(posedge clk) failSafeMode <= 1'b0;
      $display("test_wake done");
   endtask : test_wake

   task automatic test_scratch();
      wr(7'h1e, 8'ha5);
      @(posedge clk) normalMode <= 1'b0;
      stopMode <= 1'b1;
      wr(7'h1e, 8'h11);
      rdchk(7'h1e, 8'ha5);
      @(posedge clk) stopMode <= 1'b0;
      rdchk(7'h1e, 8'h00);
      @(posedge clk) normalMode <= 1'b1;
      lockLevel0 <= 1'b1;
      wr(7'h17, 8'h03);
      rdchk(7'h17, 8'h05);
      soft_pulse();
      rdchk(7'h17, 8'h05);
      rdchk(7'h18, 8'h00);
      rdchk(7'h1c, 8'h00);
      rdchk(7'h1d, 8'h01);
      rdchk(7'h1e, 8'ha5);
      rdchk(7'h1f, 8'hff);
      @(posedge clk) lockLevel0 <= 1'b0;
      soft_pulse();
      rdchk(7'h17, 8'h00);
      $display("test_scratch done");
   endtask : test_scratch

   task automatic test_lock();
      wr(7'h1d, 8'h06);
      @(posedge clk) lockLevel1Set <= 1'b1;
      rdchk(7'h1d, 8'h06);
      @(posedge clk) lockLevel1Set <= 1'b0;
      wr(7'h1d, 8'h01);
      rdchk(7'h1d, 8'h06);
      soft_pulse();
      rdchk(7'h1d, 8'h06);
      chk_byte({5'h00, thermalHigh, curLimit}, 8'h06);
      @(posedge clk) reset_n <= 1'b0;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      rdchk(7'h1d, 8'h01);
      rdchk(7'h1e, 8'h00);
      $display("test_lock done");
   endtask : test_lock

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         failCount++;
         complete_run();
      end
   end

   initial
   begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      test_regs();
      test_pins();
      test_pulse();
      test_wake();
      test_scratch();
      test_lock();
      complete_run();
   end
endmodule : tb
